// ==== angle_cfg_pkg.sv ====
package angle_cfg_pkg;

    // register indices on the host port
    localparam logic [3:0] ENABLES_IDX    = 4'h6;
    localparam logic [3:0] FILT_ERR_IDX   = 4'h7;
    localparam logic [3:0] FILT_EXP_IDX   = 4'h8;

    // field positions inside the enables word
    localparam int HARM_LIN_BIT = 19;
    localparam int PRE_DIR_BIT  = 18;
    localparam int FILT_EN_BIT  = 16;
    localparam int SEG_LIN_BIT  = 20;
    localparam int POST_DIR_BIT = 21;

    // bits loaded from the nonvolatile copy at initialization, and the software write masks
    localparam logic [15:0] OFFSET_NV_MASK  = 16'hFFF0;
    localparam logic [15:0] WINDOW_NV_MASK  = 16'h00F0;
    localparam logic [7:0]  EXP_NV_MASK     = 8'h1F;
    localparam logic [31:0] ENABLES_WR_MASK = 32'h003DFFFF;
    localparam logic [31:0] EXP_WR_MASK     = 32'h00FFFFFF;

    // values after reset
    localparam logic [31:0] ENABLES_RST = 32'h00000000;
    localparam logic [31:0] FILT_RST    = 32'h00000000;

    // live configuration handed to the datapath
    typedef struct packed {
        logic        harmonic_lin_enable;
        logic        segmented_lin_enable;
        logic        pre_lin_direction;
        logic        post_lin_direction;
        logic        angle_filter_enable;
        logic [15:0] output_angle_offset;
        logic [15:0] filter_reset_window;
        logic [15:0] filter_numerator_first;
        logic [15:0] filter_numerator_second;
        logic [7:0]  numerator_exponent;
    } angle_cfg_s;

    // nonvolatile image presented at initialization
    typedef struct packed {
        logic [31:0] enables_word;
        logic [15:0] nv_filter_reset_window;
        logic [15:0] nv_filter_numerator_first;
        logic [15:0] nv_numerator_exponent;
        logic [15:0] nv_filter_numerator_second;
    } nv_image_s;

endpackage

// ==== angle_filter.sv ====
`timescale 1ns/1ns
// first-order smoothing filter with an error window that flushes it
module angle_filter
    import angle_cfg_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    input  wire logic        sample_i,     // one-cycle strobe with a new angle
    input  wire logic [15:0] angle_i,      // raw angle, full circle = 65536
    input  wire logic [15:0] coef_i,       // sign-magnitude numerator
    input  wire logic [7:0]  exp_i,        // shared negative exponent
    input  wire logic [15:0] window_i,     // flush threshold, 0 disables
    output logic      [15:0] filt_o,       // filtered angle
    output logic             flush_o       // high for the sample that flushed
);
    logic [15:0] acc_ff;
    logic        primed_ff;
    logic        flush_ff;

    // signed wrap-aware error between input and held state
    wire logic signed [15:0] err     = $signed(angle_i - acc_ff);
    wire logic        [15:0] err_abs = err[15] ? 16'(-err) : 16'(err);
    // window code n is n*360/32768 deg, i.e. two 16-bit angle lsbs per code
    wire logic        [16:0] win_lsb = {window_i, 1'b0};
    wire logic               too_far = (window_i != 16'h0000)
                                     && ({1'b0, err_abs} > win_lsb);
    // magnitude / 16384, shifted right by the exponent, then the sign bit negates
    // err stays signed so a negative error sign-extends into the product
    wire logic signed [31:0] prod    = err * $signed({17'h0, coef_i[14:0]});
    wire logic signed [31:0] scaled  = prod >>> 14;
    wire logic signed [31:0] shifted = scaled >>> exp_i;
    wire logic signed [31:0] step    = coef_i[15] ? -shifted : shifted;

    // state update: flush reloads the raw sample so no stale history survives
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            acc_ff    <= 16'h0000;
            primed_ff <= 1'b0;
            flush_ff  <= 1'b0;
        end else if (sample_i) begin
            flush_ff  <= primed_ff && too_far;
            primed_ff <= 1'b1;
            if (!primed_ff || too_far) begin
                acc_ff <= angle_i;
            end else begin
                acc_ff <= acc_ff + step[15:0];
            end
        end
    end

    assign filt_o  = acc_ff;
    assign flush_o = flush_ff;

    flush_loads_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        sample_i && primed_ff && too_far |=> acc_ff == $past(angle_i))
        else $error("flush did not reload sample");
    zero_window_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        sample_i && window_i == 16'h0000 |=> !flush_ff)
        else $error("zero window still flushed");
endmodule

// ==== angle_cfg_regs.sv ====
`timescale 1ns/1ns
// host-visible configuration words with nonvolatile boot load
module angle_cfg_regs
    import angle_cfg_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    input  wire logic        nv_load_i,    // one-cycle init strobe
    input  wire nv_image_s   nv_i,
    input  wire logic [3:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    output logic      [31:0] enables_o,
    output logic      [31:0] filt_err_o,
    output logic      [31:0] filt_exp_o
);
    logic [31:0] enables_ff;
    logic [31:0] filt_err_ff;
    logic [31:0] filt_exp_ff;
    logic [31:0] rdata_ff;

    wire logic hit_en  = addr_i == ENABLES_IDX;
    wire logic hit_err = addr_i == FILT_ERR_IDX;
    wire logic hit_exp = addr_i == FILT_EXP_IDX;

    // boot images with padding bits forced to zero
    wire logic [31:0] nv_en  = {nv_i.enables_word[31:16] & ENABLES_WR_MASK[31:16],
                                nv_i.enables_word[15:0] & OFFSET_NV_MASK};
    wire logic [31:0] nv_err = {nv_i.nv_filter_reset_window & WINDOW_NV_MASK,
                                nv_i.nv_filter_numerator_first};
    wire logic [31:0] nv_exp = {8'h00, nv_i.nv_numerator_exponent[7:0] & EXP_NV_MASK,
                                nv_i.nv_filter_numerator_second};

    // init load first, then plain software writes
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            enables_ff  <= ENABLES_RST;
            filt_err_ff <= FILT_RST;
            filt_exp_ff <= FILT_RST;
        end else if (nv_load_i) begin
            enables_ff  <= nv_en;
            filt_err_ff <= nv_err;
            filt_exp_ff <= nv_exp;
        end else if (wr_i) begin
            if (hit_en)  enables_ff  <= wdata_i & ENABLES_WR_MASK;
            if (hit_err) filt_err_ff <= wdata_i;
            if (hit_exp) filt_exp_ff <= wdata_i & EXP_WR_MASK;
        end
    end

    // read data the cycle after the strobe, unmapped reads as zero
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rdata_ff <= 32'h00000000;
        end else if (rd_i) begin
            rdata_ff <= hit_en ? enables_ff : hit_err ? filt_err_ff
                      : hit_exp ? filt_exp_ff : 32'h00000000;
        end
    end

    assign rdata_o    = rdata_ff;
    assign enables_o  = enables_ff;
    assign filt_err_o = filt_err_ff;
    assign filt_exp_o = filt_exp_ff;
endmodule

// ==== angle_pipeline.sv ====
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
// Functional notes
// - harmonic bit set applies harmonic linearization
// - pre bit chooses angle sense before linearization
// - filter bit routes angle through filter
// - subtract zero offset after linearization
// - init loads offset 15:4, clears 3:0
// - error beyond window resets and flushes filter
// - zero window disables flush comparison
// - window lsb is 360/32768 degrees
// - init loads window 23:20, clears rest
// - numerators are sign-magnitude over 16384
// - numerators scaled by two to minus exponent
// - init loads exponent 20:16, clears 23:21
// - segmented bit set applies segmented linearization
// - post bit chooses angle sense after linearization
module angle_pipeline
    import angle_cfg_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    input  wire logic        nv_load_i,       // init strobe from boot logic
    input  wire nv_image_s   nv_i,            // nonvolatile field copy
    input  wire logic [3:0]  addr_i,          // register index
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,         // valid the cycle after rd_i
    input  wire logic        sample_i,        // one-cycle new raw angle
    input  wire logic [15:0] angle_i,         // raw angle, full circle 65536
    input  wire logic [15:0] harm_corr_i,     // correction from harmonic table
    input  wire logic [15:0] seg_corr_i,      // correction from segment table
    output logic      [15:0] angle_o,         // processed angle
    output logic             angle_valid_o    // one-cycle pulse with angle_o
);
    // pipeline states; one sample in flight at a time
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FILT = 2'b01,
        ST_LIN  = 2'b10,
        ST_OUT  = 2'b11
    } stage_e;

    stage_e      state_ff;
    stage_e      nxt_state;
    angle_cfg_s  cfg_ff;          // snapshot held for the whole sample
    logic [15:0] raw_ff;          // captured raw angle
    logic [15:0] work_ff;         // angle between stages
    logic [15:0] angle_ff;
    logic        valid_ff;
    logic [31:0] enables_w;
    logic [31:0] filt_err_w;
    logic [31:0] filt_exp_w;
    logic [15:0] filt_w;
    logic        filt_pulse;

    angle_cfg_regs u_regs (
        .clk_sys_i  (clk_sys_i),
        .rst_i      (rst_i),
        .nv_load_i  (nv_load_i),
        .nv_i       (nv_i),
        .addr_i     (addr_i),
        .wdata_i    (wdata_i),
        .wr_i       (wr_i),
        .rd_i       (rd_i),
        .rdata_o    (rdata_o),
        .enables_o  (enables_w),
        .filt_err_o (filt_err_w),
        .filt_exp_o (filt_exp_w)
    );

    // live fields decoded from the register words
    wire angle_cfg_s live_cfg = '{
        harmonic_lin_enable:     enables_w[HARM_LIN_BIT],
        segmented_lin_enable:    enables_w[SEG_LIN_BIT],
        pre_lin_direction:       enables_w[PRE_DIR_BIT],
        post_lin_direction:      enables_w[POST_DIR_BIT],
        angle_filter_enable:     enables_w[FILT_EN_BIT],
        output_angle_offset:     enables_w[15:0],
        filter_reset_window:     filt_err_w[31:16],
        filter_numerator_first:  filt_err_w[15:0],
        filter_numerator_second: filt_exp_w[15:0],
        numerator_exponent:      filt_exp_w[23:16]
    };

    // filter runs only when enabled; otherwise the sample bypasses it
    assign filt_pulse = (state_ff == ST_FILT) && cfg_ff.angle_filter_enable;

    angle_filter u_filt (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .sample_i  (filt_pulse),
        .angle_i   (raw_ff),
        .coef_i    (cfg_ff.filter_numerator_first),
        .exp_i     (cfg_ff.numerator_exponent),
        .window_i  (cfg_ff.filter_reset_window),
        .filt_o    (filt_w),
        .flush_o   ()
    );

    // direction flip: counterclockwise sense mirrors the angle modulo circle
    function automatic logic [15:0] dir_apply(input logic ccw, input logic [15:0] a);
        dir_apply = ccw ? 16'(16'h0000 - a) : a;
    endfunction

    // stage combinations, each wrapping at the full circle
    wire logic [15:0] pre_dir  = dir_apply(cfg_ff.pre_lin_direction, work_ff);
    wire logic [15:0] harm_add = cfg_ff.harmonic_lin_enable ? harm_corr_i
                                                            : 16'h0000;
    wire logic [15:0] seg_add  = cfg_ff.segmented_lin_enable ? seg_corr_i
                                                             : 16'h0000;
    wire logic [15:0] lin      = 16'(pre_dir + seg_add + harm_add);
    wire logic [15:0] post_dir = dir_apply(cfg_ff.post_lin_direction, lin);
    wire logic [15:0] offset_o = 16'(post_dir - cfg_ff.output_angle_offset);

    // next state: idle waits for a sample, then walks the stages
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: nxt_state = sample_i ? ST_FILT : ST_IDLE;
            ST_FILT: nxt_state = ST_LIN;
            ST_LIN:  nxt_state = ST_OUT;
            ST_OUT:  nxt_state = ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end

    // sequencing; samples arriving while busy are dropped, not merged
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_ff <= ST_IDLE;
            cfg_ff   <= '0;
            raw_ff   <= 16'h0000;
            work_ff  <= 16'h0000;
            angle_ff <= 16'h0000;
            valid_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            valid_ff <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    if (sample_i) begin
                        cfg_ff <= live_cfg;
                        raw_ff <= angle_i;
                    end
                end
                ST_FILT: begin
                    // filter output lands next cycle; take raw when bypassed
                    work_ff <= raw_ff;
                end
                ST_LIN: begin
                    if (cfg_ff.angle_filter_enable) begin
                        work_ff <= filt_w;
                    end
                end
                ST_OUT: begin
                    angle_ff <= offset_o;
                    valid_ff <= 1'b1;
                end
                default: begin
                    valid_ff <= 1'b0;
                end
            endcase
        end
    end

    assign angle_o       = angle_ff;
    assign angle_valid_o = valid_ff;

    // checks
    cfg_frozen_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        state_ff != ST_IDLE |=> $stable(cfg_ff) || $past(state_ff) == ST_IDLE)
        else $error("config changed mid-sample");
    sample_latency_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        state_ff == ST_IDLE && sample_i |-> ##4 angle_valid_o)
        else $error("output not four cycles after sample");
    bypass_path_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        state_ff == ST_LIN && !cfg_ff.angle_filter_enable |=> work_ff == raw_ff)
        else $error("bypass did not use raw angle");
    offset_sub_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        state_ff == ST_OUT |=> angle_o == 16'($past(post_dir)
                                 - $past(cfg_ff.output_angle_offset)))
        else $error("offset not subtracted");
    harm_gate_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !cfg_ff.harmonic_lin_enable |-> harm_add == 16'h0000)
        else $error("harmonic applied while disabled");
    seg_gate_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        cfg_ff.segmented_lin_enable |-> seg_add == seg_corr_i)
        else $error("segmented not applied");
    pre_dir_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        cfg_ff.pre_lin_direction |-> 16'(pre_dir + work_ff) == 16'h0000)
        else $error("pre direction wrong");
    post_dir_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !cfg_ff.post_lin_direction |-> post_dir == lin)
        else $error("post direction wrong");
    boot_pad_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        nv_load_i |=> enables_w[3:0] == 4'h0 && filt_err_w[19:16] == 4'h0
                      && filt_exp_w[23:21] == 3'h0)
        else $error("boot padding not zero");
    win_map_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        filt_pulse |-> cfg_ff.filter_reset_window == $past(filt_err_w[31:16]))
        else $error("window field misrouted");
    num_map_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        state_ff == ST_IDLE && sample_i |=> cfg_ff.numerator_exponent
                                            == $past(filt_exp_w[23:16]))
        else $error("exponent not captured");
endmodule

// ==== angle_pipeline_tb.sv ====
`timescale 1ns/1ns
// self-checking bench: host port, nonvolatile boot load and the sample stream
module angle_pipeline_tb
    import angle_cfg_pkg::*;
;
    typedef struct {
        logic [15:0] v;    // expected angle
        int          due;  // cycle in which the result must appear
    } pend_s;

    logic        clk_sys_i;
    logic        rst_i;
    logic        nv_load_i;
    nv_image_s   nv_i;
    logic [3:0]  addr_i;
    logic [31:0] wdata_i;
    logic        wr_i;
    logic        rd_i;
    logic [31:0] rdata_o;
    logic        sample_i;
    logic [15:0] angle_i;
    logic [15:0] harm_corr_i;
    logic [15:0] seg_corr_i;
    logic [15:0] angle_o;
    logic        angle_valid_o;
    int          n_errors;       // mismatches seen
    int          check_count;    // comparisons made
    int          cyc;            // edges since time zero
    logic [31:0] en_m, w7_m, w8_m;  // mirrors of the three words
    logic [15:0] acc_m;          // mirror of the filter state
    logic        primed_m;       // filter has taken its first sample
    logic [31:0] rd_exp, rx_q;   // read expectation, launched and pending
    logic        rd_q, take_q;   // a read or an accepted sample was taken
    logic        accept;         // bench expects this sample to be taken
    logic [15:0] exp_next;       // expected angle of the sample in flight
    pend_s       q[$];           // results still owed by the design
    nv_image_s   nv_v;
    logic [15:0] x;
    int          m;

    angle_pipeline dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .nv_load_i(nv_load_i),
        .nv_i(nv_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .sample_i(sample_i), .angle_i(angle_i),
        .harm_corr_i(harm_corr_i), .seg_corr_i(seg_corr_i), .angle_o(angle_o),
        .angle_valid_o(angle_valid_o));

    // 100 MHz clock
    always #5 clk_sys_i = ~clk_sys_i;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("errors %0d, checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // filter model: first sample or a flush loads the raw angle, else one step
    function automatic logic [15:0] filt_step(input logic [15:0] a);
        int e, p;
        e = int'($signed(a - acc_m));
        if (!primed_m || (w7_m[31:16] != 16'h0000 && (e < 0 ? -e : e) > 2 * int'(w7_m[31:16])))
            acc_m = a;
        else begin
            p = (e * int'(w7_m[14:0])) >>> 14;
            p = p >>> w8_m[23:16];
            if (w7_m[15]) p = -p;
            acc_m = acc_m + p[15:0];
        end
        primed_m = 1'b1;
        return acc_m;
    endfunction

    // stage order: filter, pre sense, linearizations, post sense, offset
    function automatic logic [15:0] expect_angle(input logic [15:0] a, h, s);
        logic [15:0] b;
        b = en_m[FILT_EN_BIT] ? filt_step(a) : a;
        if (en_m[PRE_DIR_BIT]) b = -b;
        b = b + (en_m[SEG_LIN_BIT] ? s : 16'h0000) + (en_m[HARM_LIN_BIT] ? h : 16'h0000);
        if (en_m[POST_DIR_BIT]) b = -b;
        return b - en_m[15:0];
    endfunction

    // every strobe is set exactly once per edge, so back-to-back calls never race
    task automatic drv(input logic w, r, s, l);
        wr_i <= w;
        rd_i <= r;
        sample_i <= s;
        nv_load_i <= l;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        addr_i <= a;
        wdata_i <= d;
        drv(1'b1, 1'b0, 1'b0, 1'b0);
        @(posedge clk_sys_i);
        if (a == ENABLES_IDX) en_m = d & ENABLES_WR_MASK;
        if (a == FILT_ERR_IDX) w7_m = d;
        if (a == FILT_EXP_IDX) w8_m = d & EXP_WR_MASK;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        addr_i <= a;
        rd_exp <= e;
        drv(1'b0, 1'b1, 1'b0, 1'b0);
        @(posedge clk_sys_i);
    endtask

    task automatic idle(input int n);
        drv(1'b0, 1'b0, 1'b0, 1'b0);
        repeat (n) @(posedge clk_sys_i);
    endtask

    // corrections only change with an accepted sample, they must hold meanwhile
    task automatic smp(input logic [15:0] a, input logic acc);
        logic [15:0] h, s;
        h = 16'($urandom);
        s = 16'($urandom);
        angle_i <= a;
        accept <= acc;
        if (acc) begin
            harm_corr_i <= h;
            seg_corr_i <= s;
            exp_next <= expect_angle(a, h, s);
        end
        drv(1'b0, 1'b0, 1'b1, 1'b0);
        @(posedge clk_sys_i);
    endtask

    // note what each edge took
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        rd_q <= rd_i;
        rx_q <= rd_exp;
        take_q <= sample_i & accept;
    end

    // compare mid-cycle, where registered outputs have settled
    always @(negedge clk_sys_i) begin
        if (!rst_i) begin
            if (rd_q) chk(rdata_o, rx_q);
            if (take_q) q.push_back('{v: exp_next, due: cyc + 3});
            if (q.size() > 0 && q[0].due == cyc) begin
                chk({31'h0, angle_valid_o}, 32'h1);
                chk({16'h0, angle_o}, {16'h0, q[0].v});
                void'(q.pop_front());
            end else if (angle_valid_o !== 1'b0) chk({31'h0, angle_valid_o}, 32'h0);
        end
    end

    // hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        n_errors++;
        report_and_stop();
    end

    initial begin
        clk_sys_i = 0; rst_i = 1; nv_load_i = 0; nv_i = '0; addr_i = 4'h0;
        wdata_i = 32'h0; wr_i = 0; rd_i = 0; sample_i = 0; angle_i = 16'h0;
        harm_corr_i = 16'h0; seg_corr_i = 16'h0; n_errors = 0; check_count = 0;
        cyc = 0; en_m = 32'h0; w7_m = 32'h0; w8_m = 32'h0; acc_m = 16'h0;
        primed_m = 0; rd_exp = 32'h0; accept = 0; exp_next = 16'h0;
        void'($urandom(1));
        repeat (5) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rd(ENABLES_IDX, 32'h0);
        rd(FILT_ERR_IDX, 32'h0);
        rd(FILT_EXP_IDX, 32'h0);
        // boot load; filter enable kept clear so the filter stays unprimed
        nv_v = {$urandom & 32'hFFFE_FFFF, 32'($urandom), 32'($urandom)};
        nv_i <= nv_v;
        drv(1'b0, 1'b0, 1'b0, 1'b1);
        @(posedge clk_sys_i);
        en_m = nv_v.enables_word & 32'h003D_FFF0;
        w7_m = {nv_v.nv_filter_reset_window & WINDOW_NV_MASK, nv_v.nv_filter_numerator_first};
        w8_m = {8'h00, nv_v.nv_numerator_exponent[7:0] & EXP_NV_MASK,
                nv_v.nv_filter_numerator_second};
        rd(ENABLES_IDX, en_m);
        rd(FILT_ERR_IDX, w7_m);
        rd(FILT_EXP_IDX, w8_m);
        rd(4'hF, 32'h0);
        // random writes with back-to-back readback, one unmapped index among them
        for (m = 0; m < 16; m++) begin
            x = 16'($urandom_range(0, 3));
            wr(x == 0 ? 4'h3 : 4'h5 + x[3:0], $urandom);
            rd(x == 0 ? 4'h3 : 4'h5 + x[3:0],
               x == 1 ? en_m : x == 2 ? w7_m : x == 3 ? w8_m : 32'h0);
        end
        // every sense and linearization combination, filter bypassed
        for (m = 0; m < 32; m++) begin
            wr(ENABLES_IDX, {10'h000, 4'(m), 2'b00, 16'($urandom)});
            smp(16'($urandom), 1'b1);
            idle(3);
        end
        // a write and a refused sample while a sample is in flight
        for (m = 0; m < 4; m++) begin
            smp(16'($urandom), 1'b1);
            wr(ENABLES_IDX, $urandom & 32'h003C_FFFF);
            smp(16'($urandom), 1'b0);
            idle(2);
        end
        // window edge: ten lsbs stay inside a window of five, eleven flush
        wr(FILT_ERR_IDX, {16'd5, 16'h0000});
        wr(FILT_EXP_IDX, 32'h0);
        wr(ENABLES_IDX, {16'h0001, 16'($urandom)});
        x = 16'($urandom);
        smp(x, 1'b1);
        idle(3);
        smp(x + 16'd10, 1'b1);
        idle(3);
        smp(x + 16'd11, 1'b1);
        idle(3);
        wr(FILT_ERR_IDX, 32'h0);
        smp(x + 16'd30011, 1'b1);
        idle(3);
        // random coefficients, signs, exponents and windows
        for (m = 0; m < 80; m++) begin
            if (m % 20 == 0) begin
                wr(FILT_ERR_IDX, {16'($urandom_range(0, 300)), 16'($urandom)});
                wr(FILT_EXP_IDX, {8'h00, 8'($urandom_range(0, 3)), 16'($urandom)});
            end
            smp(x + 16'($urandom_range(0, 1000)), 1'b1);
            idle(3);
        end
        idle(6);
        report_and_stop();
    end
endmodule
